//--- design/fpec_top.sv
// flash program/erase controller with AXI4-Lite register slave
// assumes an AXI4-Lite master on aclk
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fpec_consts.svh"
module fpec_top
    import fpec_pkg::*;
#(
    parameter int CYC_WORD  = `FPEC_CYC_WORD,
    parameter int CYC_ERASE = `FPEC_CYC_ERASE
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        low_voltage_pin,
    input  wire logic        protect_hit,
    input  wire logic        array_fail,
    output logic [31:0]      array_addr,
    output logic [31:0]      array_data,
    output logic             array_prog,
    output logic             array_erase,
    output logic             array_all,
    output logic             array_row,
    output logic             irq
);
    fpec_seq_if sq ();

    logic        gate_r;
    logic        start_r;
    logic [3:0]  op_r;
    logic        perr_r;
    logic        lverr_r;
    logic [1:0]  key_r;
    logic [31:0] addr_r;
    logic [31:0] data_r;
    logic [`FPEC_IRQ_W-1:0] ist_r;
    logic [`FPEC_IRQ_W-1:0] imask_r;
    logic        launch_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        lv_sync;
    logic        protect_sync;
    logic        fail_sync;

    fpec_sync u_sync_lv (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (low_voltage_pin),
        .q       (lv_sync)
    );
    fpec_sync u_sync_prot (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (protect_hit),
        .q       (protect_sync)
    );
    fpec_sync u_sync_fail (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (array_fail),
        .q       (fail_sync)
    );

    fpec_seq #(
        .CYC_WORD  (CYC_WORD),
        .CYC_ERASE (CYC_ERASE)
    ) u_seq (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .sq          (sq),
        .lv_sense    (lv_sync),
        .protect_hit (protect_sync),
        .array_fail  (fail_sync),
        .array_prog  (array_prog),
        .array_erase (array_erase),
        .array_all   (array_all),
        .array_row   (array_row)
    );

    // write channel: address and data taken in either order, one at a time
    wire        aw_ok   = !aw_held_r && !bvalid_r;
    wire        w_ok    = !w_held_r && !bvalid_r;
    assign s_axi_awready = aw_ok;
    assign s_axi_wready  = w_ok;
    wire        aw_take = s_axi_awvalid && aw_ok;
    wire        w_take  = s_axi_wvalid && w_ok;
    wire        aw_have = aw_held_r || aw_take;
    wire        w_have  = w_held_r || w_take;
    wire        wr_go   = aw_have && w_have;
    wire [7:0]  wa      = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wd      = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0]  ws      = w_held_r ? wstrb_r : s_axi_wstrb;
    wire        wa_ok   = wa[1:0] == 2'b00;

    wire wr_ctrl  = wr_go && wa_ok && wa[7:2] == 6'(`FPEC_OFF_CTRL >> 2);
    wire wr_key   = wr_go && wa_ok && wa[7:2] == 6'(`FPEC_OFF_KEY >> 2);
    wire wr_addr  = wr_go && wa_ok && wa[7:2] == 6'(`FPEC_OFF_ADDR >> 2);
    wire wr_data  = wr_go && wa_ok && wa[7:2] == 6'(`FPEC_OFF_DATA >> 2);
    wire wr_ist   = wr_go && wa_ok && wa[7:2] == 6'(`FPEC_OFF_IRQ_STAT >> 2);
    wire wr_imask = wr_go && wa_ok && wa[7:2] == 6'(`FPEC_OFF_IRQ_MASK >> 2);
    wire wr_hit   = wr_ctrl | wr_key | wr_addr | wr_data | wr_ist | wr_imask;

    // read channel
    wire        rd_go   = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = !rvalid_r;
    wire [7:0]  ra      = s_axi_araddr;
    wire        ra_ok   = ra[1:0] == 2'b00;

    wire [31:0] ctrl_view;
    assign ctrl_view = {16'h0000, start_r, gate_r, perr_r, lverr_r,
                        gate_r & lv_sync, 7'h00, op_r};  // RULE_07 RULE_15
    wire [31:0] ist_view   = {{(32-`FPEC_IRQ_W){1'b0}}, ist_r};
    wire [31:0] imask_view = {{(32-`FPEC_IRQ_W){1'b0}}, imask_r};
    wire [31:0] key_view   = {30'h0, key_r};

    wire r_ctrl  = ra_ok && ra[7:2] == 6'(`FPEC_OFF_CTRL >> 2);
    wire r_key   = ra_ok && ra[7:2] == 6'(`FPEC_OFF_KEY >> 2);
    wire r_addr  = ra_ok && ra[7:2] == 6'(`FPEC_OFF_ADDR >> 2);
    wire r_data  = ra_ok && ra[7:2] == 6'(`FPEC_OFF_DATA >> 2);
    wire r_ist   = ra_ok && ra[7:2] == 6'(`FPEC_OFF_IRQ_STAT >> 2);
    wire r_imask = ra_ok && ra[7:2] == 6'(`FPEC_OFF_IRQ_MASK >> 2);
    wire r_hit   = r_ctrl | r_key | r_addr | r_data | r_ist | r_imask;
    wire [31:0] rd_mux = r_ctrl  ? ctrl_view  :
                         r_key   ? key_view   :
                         r_addr  ? addr_r     :
                         r_data  ? data_r     :
                         r_ist   ? ist_view   :
                         r_imask ? imask_view : 32'h0000_0000;

    // lane 1 carries start/gate, lane 0 the op select
    wire        ln0      = ws[0];
    wire        ln1      = ws[1];
    wire        wr_gate  = wr_ctrl && ln1;
    wire        new_gate = wd[`FPEC_BIT_GATE];
    wire        unlocked = key_r == 2'b10;
    // start needs the gate already armed; arming and starting in one write is refused
    wire        start_ok = wr_gate && wd[`FPEC_BIT_START] && gate_r && unlocked
                           && !sq.busy;  // RULE_01 RULE_04 RULE_16
    wire        op_ok    = wr_ctrl && ln0 && !gate_r;  // RULE_08
    wire        any_acc  = wr_go || rd_go;
    wire        key_one  = wr_key && wd == `FPEC_KEY1;
    wire        key_two  = wr_key && wd == `FPEC_KEY2 && key_r == 2'b01;

    wire        clr_flags = launch_r && op_r == 4'(FPEC_OP_NOP0);  // RULE_14
    wire [`FPEC_IRQ_W-1:0] ev;
    assign ev[`FPEC_IRQ_DONE] = sq.done;
    assign ev[`FPEC_IRQ_ERR]  = sq.done && sq.fail;

    assign sq.launch      = launch_r;
    assign sq.op          = op_r;
    assign sq.addr        = addr_r;
    assign sq.data        = data_r;
    assign sq.detector_on = gate_r;  // RULE_04

    assign array_addr    = addr_r;
    assign array_data    = data_r;
    assign irq           = |(ist_r & imask_r);
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // only the gate is reset; the other control bits keep their value
    always_ff @(posedge aclk) begin
        if (!aresetn)
            gate_r <= 1'b0;  // RULE_03
        else if (wr_gate)
            gate_r <= new_gate;  // RULE_04
    end

    always_ff @(posedge aclk) begin
        if (start_ok)
            start_r <= 1'b1;  // RULE_02
        else if (sq.done)
            start_r <= 1'b0;  // RULE_02
        if (op_ok)
            op_r <= wd[`FPEC_OP_MSB:0];  // RULE_08
        if (sq.done && sq.fail)
            perr_r <= 1'b1;  // RULE_05
        else if (clr_flags)
            perr_r <= 1'b0;  // RULE_14
        if (sq.done && sq.low_voltage_hit)
            lverr_r <= 1'b1;  // RULE_06
        else if (clr_flags)
            lverr_r <= 1'b0;  // RULE_14
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_r    <= 2'b00;
            launch_r <= 1'b0;
            addr_r   <= 32'h0000_0000;
            data_r   <= 32'h0000_0000;
            ist_r    <= '0;
            imask_r  <= '0;
        end else begin
            launch_r <= start_ok;  // RULE_02
            if (key_two)
                key_r <= 2'b10;  // RULE_16
            else if (key_one)
                key_r <= 2'b01;  // RULE_16
            else if (any_acc)
                key_r <= 2'b00;  // RULE_16
            if (wr_addr && !start_r)
                addr_r <= wd;
            if (wr_data && !start_r)
                data_r <= wd;
            // a new event wins over a same-cycle clear
            ist_r <= (ist_r & ~(wr_ist ? wd[`FPEC_IRQ_W-1:0] : '0)) | ev;
            if (wr_imask)
                imask_r <= wd[`FPEC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'b00;
        end else begin
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            aw_held_r <= aw_have && !wr_go;
            w_held_r  <= w_have && !wr_go;
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'b00;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= r_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule // fpec_top
`default_nettype wire

//--- inc/fpec_consts.svh
// flash program/erase control constants
// assumes word-aligned 32-bit registers
//
// Notes on behaviour
// RULE_01: start accepted only when gated and unlocked
// RULE_02: start bit stays set until operation ends
// RULE_03: reset clears only the write-enable gate
// RULE_04: gate permits start, powers low-voltage detector
// RULE_05: program error flag read-only, set on failure
// RULE_06: low-voltage error set by detector during operation
// RULE_07: low-voltage status follows detector while enabled
// RULE_08: operation select writable only with gate clear
// RULE_09: code 0101 erases whole array unless protected
// RULE_10: code 0100 erases addressed page unless protected
// RULE_11: code 0011 programs addressed row unless protected
// RULE_12: code 0001 programs addressed word unless protected
// RULE_13: codes 0000, 0010, 0110 do nothing
// RULE_14: start with code 0000 clears both error flags
// RULE_15: unimplemented control bits read zero, ignore writes
// RULE_16: two key writes grant exactly one start write
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH

`define FPEC_OFF_CTRL      8'h00
`define FPEC_OFF_KEY       8'h04
`define FPEC_OFF_ADDR      8'h08
`define FPEC_OFF_DATA      8'h0C
`define FPEC_OFF_IRQ_STAT  8'h10
`define FPEC_OFF_IRQ_MASK  8'h14

`define FPEC_BIT_START     15
`define FPEC_BIT_GATE      14
`define FPEC_BIT_PERR      13
`define FPEC_BIT_LVERR     12
`define FPEC_BIT_LVSTAT    11
`define FPEC_OP_MSB        3

`define FPEC_KEY1          32'h0000_AA99
`define FPEC_KEY2          32'h0000_5566

`define FPEC_IRQ_DONE      0
`define FPEC_IRQ_ERR       1
`define FPEC_IRQ_W         2

`define FPEC_CLK_MHZ       50
`define FPEC_T_WORD_US     20
`define FPEC_T_ERASE_US    200
`define FPEC_CYC_WORD      (`FPEC_T_WORD_US * `FPEC_CLK_MHZ)
`define FPEC_CYC_ERASE     (`FPEC_T_ERASE_US * `FPEC_CLK_MHZ)

`endif

//--- inc/fpec_pkg.sv
// flash program/erase control types
// assumes fpec_consts.svh is on the include path
package fpec_pkg;
    typedef enum logic [3:0] {
        FPEC_OP_NOP0  = 4'h0,
        FPEC_OP_WORD  = 4'h1,
        FPEC_OP_NOP2  = 4'h2,
        FPEC_OP_ROW   = 4'h3,
        FPEC_OP_PAGE  = 4'h4,
        FPEC_OP_CHIP  = 4'h5,
        FPEC_OP_NOP6  = 4'h6
    } fpec_op_t;

    typedef enum logic [1:0] {
        FPEC_ST_IDLE = 2'b00,
        FPEC_ST_RUN  = 2'b01,
        FPEC_ST_DONE = 2'b10
    } fpec_state_t;
endpackage

//--- inc/fpec_seq_if.sv
// register slave to sequencer carrier
// assumes both ends run on aclk
`timescale 1ns/1ns
`default_nettype none
interface fpec_seq_if;
    logic        launch;
    logic [3:0]  op;
    logic [31:0] addr;
    logic [31:0] data;
    logic        detector_on;
    logic        busy;
    logic        done;
    logic        fail;
    logic        low_voltage_hit;
    modport regs (output launch, output op, output addr, output data, output detector_on,
                  input busy, input done, input fail, input low_voltage_hit);
    modport seq  (input launch, input op, input addr, input data, input detector_on,
                  output busy, output done, output fail, output low_voltage_hit);
endinterface
`default_nettype wire

//--- design/fpec_sync.sv
// two-flop synchroniser for pin-level inputs
// assumes the input is asynchronous to aclk
`timescale 1ns/1ns
`default_nettype none
module fpec_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // fpec_sync
`default_nettype wire

//--- design/fpec_seq.sv
// flash sequencer: array strobes and operation timing
// assumes synced fail and protect levels
`timescale 1ns/1ns
`default_nettype none
`include "fpec_consts.svh"
module fpec_seq
    import fpec_pkg::*;
#(
    parameter int CYC_WORD  = `FPEC_CYC_WORD,
    parameter int CYC_ERASE = `FPEC_CYC_ERASE
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    fpec_seq_if.seq    sq,
    input  wire logic  lv_sense,
    input  wire logic  protect_hit,
    input  wire logic  array_fail,
    output logic       array_prog,
    output logic       array_erase,
    output logic       array_all,
    output logic       array_row
);
    if (CYC_WORD < 1 || CYC_ERASE < 1 || CYC_WORD >= (1 << 24) || CYC_ERASE >= (1 << 24)) begin : g_bad_cyc
        $error("fpec_seq: bad cycle counts");
    end

    fpec_state_t state_r;
    logic [23:0] cnt_r;
    logic        fail_r;
    logic        lvhit_r;

    wire is_word  = sq.op == FPEC_OP_WORD;  // RULE_12
    wire is_row   = sq.op == FPEC_OP_ROW;   // RULE_11
    wire is_page  = sq.op == FPEC_OP_PAGE;  // RULE_10
    wire is_chip  = sq.op == FPEC_OP_CHIP;  // RULE_09
    wire is_real  = is_word | is_row | is_page | is_chip;  // RULE_13
    wire [23:0] load_cnt = (is_page | is_chip) ? 24'(CYC_ERASE) : 24'(CYC_WORD);
    wire lv_now   = sq.detector_on & lv_sense;

    assign sq.busy            = state_r != FPEC_ST_IDLE;
    assign sq.done            = state_r == FPEC_ST_DONE;
    assign sq.fail            = fail_r;
    assign sq.low_voltage_hit = lvhit_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= FPEC_ST_IDLE;
            cnt_r       <= 24'h000000;
            fail_r      <= 1'b0;
            lvhit_r     <= 1'b0;
            array_prog  <= 1'b0;
            array_erase <= 1'b0;
            array_all   <= 1'b0;
            array_row   <= 1'b0;
        end else begin
            case (state_r)
                FPEC_ST_IDLE: begin
                    if (sq.launch) begin
                        lvhit_r <= 1'b0;
                        fail_r  <= 1'b0;
                        cnt_r   <= load_cnt;
                        if (!is_real) begin
                            state_r <= FPEC_ST_DONE;
                        end else if (protect_hit) begin
                            fail_r  <= 1'b1;  // RULE_05
                            state_r <= FPEC_ST_DONE;
                        end else begin
                            array_prog  <= is_word | is_row;
                            array_erase <= is_page | is_chip;
                            array_all   <= is_chip;
                            array_row   <= is_row;
                            state_r     <= FPEC_ST_RUN;
                        end
                    end
                end
                FPEC_ST_RUN: begin
                    if (lv_now)
                        lvhit_r <= 1'b1;  // RULE_06
                    if (cnt_r <= 24'h000001) begin
                        fail_r      <= array_fail | lvhit_r | lv_now;  // RULE_05
                        array_prog  <= 1'b0;
                        array_erase <= 1'b0;
                        array_all   <= 1'b0;
                        array_row   <= 1'b0;
                        state_r     <= FPEC_ST_DONE;
                    end else begin
                        cnt_r <= cnt_r - 24'h000001;
                    end
                end
                FPEC_ST_DONE: state_r <= FPEC_ST_IDLE;
                default:      state_r <= FPEC_ST_IDLE;
            endcase
        end
    end
endmodule // fpec_seq
`default_nettype wire

//--- dv/fpec_top_properties.sv
// port checker for the flash program/erase controller
// assumes bind to fpec_top; counts follow its parameters
`timescale 1ns/1ns
`default_nettype none
`include "fpec_consts.svh"
module fpec_chk #(
    parameter int CYC_WORD  = 4,
    parameter int CYC_ERASE = 8
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        protect_hit,
    input wire logic [31:0] array_addr,
    input wire logic        array_prog,
    input wire logic        array_erase,
    input wire logic        array_all,
    input wire logic        array_row
);
    logic [23:0] prog_cnt_r;
    logic [23:0] erase_cnt_r;
    logic        ctrl_rd_r;
    wire         busy = array_prog | array_erase;

    always_ff @(posedge aclk) begin
        prog_cnt_r  <= array_prog ? prog_cnt_r + 24'h1 : 24'h0;
        erase_cnt_r <= array_erase ? erase_cnt_r + 24'h1 : 24'h0;
        if (s_axi_arvalid && s_axi_arready) begin
            ctrl_rd_r <= (s_axi_araddr == `FPEC_OFF_CTRL);
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PROG_XOR_ERASE: assert property (!(array_prog && array_erase))
        else $error("program and erase strobes overlap");
    AST_ALL_IS_ERASE: assert property (array_all |-> array_erase)
        else $error("whole-array strobe without erase");
    AST_ROW_IS_PROG: assert property (array_row |-> array_prog)
        else $error("row strobe without program");
    // synchroniser and launch latency fit inside six cycles
    AST_PROTECT_BLOCKS: assert property (protect_hit [*6] |=> !$rose(busy))
        else $error("operation started on a protected region");
    AST_PROG_LEN: assert property ($fell(array_prog) |-> prog_cnt_r >= CYC_WORD && prog_cnt_r <= CYC_WORD + 2)
        else $error("program strobe length off");
    AST_ERASE_LEN: assert property ($fell(array_erase) |-> erase_cnt_r >= CYC_ERASE && erase_cnt_r <= CYC_ERASE + 2)
        else $error("erase strobe length off");
    AST_ADDR_HELD: assert property (busy && $past(busy) |-> $stable(array_addr))
        else $error("target address moved during an operation");
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> !busy)
        else $error("strobe active right after reset");
    AST_CTRL_UNIMPL: assert property (s_axi_rvalid && ctrl_rd_r |-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[10:4] == 7'h0)
        else $error("unimplemented control bits read nonzero");
endmodule // fpec_chk

bind fpec_top fpec_chk #(.CYC_WORD(CYC_WORD), .CYC_ERASE(CYC_ERASE)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .protect_hit(protect_hit), .array_addr(array_addr), .array_prog(array_prog),
    .array_erase(array_erase), .array_all(array_all), .array_row(array_row));
`default_nettype wire

//--- dv/fpec_flash_model.sv
// behavioural flash array answering the controller's strobes
// assumes the bench commands protection, failure and low supply
`timescale 1ns/1ns
`default_nettype none
module fpec_flash_model (
    input wire logic        aclk,
    input wire logic        protect_on,
    input wire logic        fail_on,
    input wire logic        lv_on,
    input wire logic [31:0] array_addr,
    input wire logic        array_prog,
    input wire logic        array_erase,
    output logic            protect_hit,
    output logic            array_fail,
    output logic            low_voltage_pin
);
    // upper half of the map is protected
    assign protect_hit = protect_on & array_addr[31];
    // fails only while an op runs
    always_ff @(posedge aclk) begin
        array_fail <= fail_on & (array_prog | array_erase);
    end
    assign low_voltage_pin = lv_on;
endmodule // fpec_flash_model
`default_nettype wire

//--- dv/test_flash_program_erase_control.sv
// self-checking bench for fpec_top
// assumes the flash model and bound checker
`timescale 1ns/1ns
`default_nettype none
`include "fpec_consts.svh"
module test_flash_program_erase_control import fpec_pkg::*;;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, started;
    logic        lv_pin, prot, afail, prog, erase, all, row, protect_on, fail_on, lv_on;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb, seen;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] wdata, rdata, rd, array_addr, array_data;
    int          fails, check_count, n;
    localparam logic [3:0] EXP [0:6] = '{4'h0, 4'h1, 4'h0, 4'h5, 4'h2, 4'hA, 4'h0};

    fpec_top #(.CYC_WORD(20), .CYC_ERASE(40)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_voltage_pin(lv_pin),
        .protect_hit(prot), .array_fail(afail), .array_addr(array_addr), .array_data(array_data),
        .array_prog(prog), .array_erase(erase), .array_all(all), .array_row(row), .irq(irq));
    fpec_flash_model model_u (
        .aclk(aclk), .protect_on(protect_on), .fail_on(fail_on), .lv_on(lv_on), .array_addr(array_addr),
        .array_prog(prog), .array_erase(erase), .protect_hit(prot), .array_fail(afail),
        .low_voltage_pin(lv_pin));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // sticky strobe record, held while idle; only the bench clears it
    always @(posedge aclk) if (prog | erase) seen <= seen | {all, row, erase, prog};

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        if (n == 60) begin fails++; final_report(); end
    endtask
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        resp = rresp;
        if (n == 60) begin fails++; final_report(); end
    endtask
    // leaves the gate clear for the next op select
    task automatic run_op(input logic [3:0] op);
        int k;
        wr(`FPEC_OFF_CTRL, {28'h0, op}, 4'h1);
        wr(`FPEC_OFF_CTRL, 32'h4000, 4'h2);
        wr(`FPEC_OFF_KEY, `FPEC_KEY1, 4'hF);
        wr(`FPEC_OFF_KEY, `FPEC_KEY2, 4'hF);
        wr(`FPEC_OFF_CTRL, 32'hC000, 4'h2);
        for (k = 0; k < 40; k++) begin
            rd_reg(`FPEC_OFF_CTRL);
            if (k == 0) started = rd[15];
            if (rd[15] === 1'b0) break;
        end
        if (k == 40) begin fails++; final_report(); end
        wr(`FPEC_OFF_CTRL, 32'h0, 4'h2);
    endtask

    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1; arvalid = 1'b0; rready = 1'b1;
        awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0; seen = 4'h0;
        protect_on = 1'b0; fail_on = 1'b0; lv_on = 1'b0; fails = 0; check_count = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(`FPEC_OFF_CTRL);
        check(rd & 32'hFFFF_47F0, 32'h0);
        rd_reg(8'h40);
        check({30'h0, resp}, 32'h2);
        wr(8'h40, 32'h0, 4'hF);
        check({30'h0, resp}, 32'h2);
        run_op(FPEC_OP_NOP0);
        check(rd & 32'h3000, 32'h0);
        wr(`FPEC_OFF_ADDR, 32'h120, 4'hF);
        wr(`FPEC_OFF_DATA, 32'h5A, 4'hF);
        for (int op = 0; op < 7; op++) begin
            seen <= 4'h0;
            run_op(op[3:0]);
            check({28'h0, seen}, {28'h0, EXP[op]});
            check(rd & 32'hB000, 32'h0);
            if (EXP[op] != 4'h0) check({31'h0, started}, 32'h1);
        end
        check(array_addr, 32'h120);
        check(array_data, 32'h5A);
        wr(`FPEC_OFF_CTRL, 32'h4000, 4'h2);
        wr(`FPEC_OFF_CTRL, 32'h5, 4'h1);
        wr(`FPEC_OFF_CTRL, 32'hC000, 4'h2);
        wr(`FPEC_OFF_KEY, `FPEC_KEY1, 4'hF);
        wr(`FPEC_OFF_KEY, `FPEC_KEY2, 4'hF);
        rd_reg(`FPEC_OFF_KEY);
        check(rd, 32'h2);
        wr(`FPEC_OFF_CTRL, 32'hC000, 4'h2);
        rd_reg(`FPEC_OFF_CTRL);
        check(rd & 32'h800F, 32'h6);
        lv_on <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_reg(`FPEC_OFF_CTRL);
        check(rd & 32'h0800, 32'h0800);
        wr(`FPEC_OFF_CTRL, 32'h0, 4'h2);
        rd_reg(`FPEC_OFF_CTRL);
        check(rd & 32'h0800, 32'h0);
        run_op(FPEC_OP_WORD);
        check(rd & 32'h1000, 32'h1000);
        lv_on <= 1'b0;
        run_op(FPEC_OP_NOP0);
        check(rd & 32'h3000, 32'h0);
        protect_on <= 1'b1;
        wr(`FPEC_OFF_ADDR, 32'h8000_0000, 4'hF);
        seen <= 4'h0;
        run_op(FPEC_OP_PAGE);
        check(rd & 32'h2000, 32'h2000);
        run_op(FPEC_OP_CHIP);
        check({28'h0, seen}, 32'h0);
        check(rd & 32'h2000, 32'h2000);
        protect_on <= 1'b0;
        fail_on <= 1'b1;
        run_op(FPEC_OP_NOP0);
        wr(`FPEC_OFF_ADDR, 32'h120, 4'hF);
        run_op(FPEC_OP_ROW);
        check(rd & 32'h2000, 32'h2000);
        fail_on <= 1'b0;
        run_op(FPEC_OP_NOP0);
        wr(`FPEC_OFF_IRQ_STAT, 32'h3, 4'hF);
        wr(`FPEC_OFF_IRQ_MASK, 32'h0, 4'hF);
        run_op(FPEC_OP_WORD);
        check({31'h0, irq}, 32'h0);
        wr(`FPEC_OFF_IRQ_MASK, 32'h1, 4'hF);
        check({31'h0, irq}, 32'h1);
        wr(`FPEC_OFF_IRQ_STAT, 32'h1, 4'hF);
        check({31'h0, irq}, 32'h0);
        wr(`FPEC_OFF_CTRL, 32'h3, 4'h1);
        wr(`FPEC_OFF_CTRL, 32'h4000, 4'h2);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(`FPEC_OFF_CTRL);
        check(rd & 32'h400F, 32'h3);
        final_report();
    end
endmodule // test_flash_program_erase_control
`default_nettype wire
